/* rtl/slrg_defs.svh */
// constants of the speed limit and ramp generator block
`ifndef SLRG_DEFS_SVH
`define SLRG_DEFS_SVH

// register byte offsets
`define SLRG_OFF_CTRL 8'h00
`define SLRG_OFF_MAX_SPEED 8'h04
`define SLRG_OFF_POS_LIMIT 8'h08
`define SLRG_OFF_NEG_LIMIT 8'h0C
`define SLRG_OFF_RAMP_UP 8'h10
`define SLRG_OFF_RAMP_DOWN 8'h14
`define SLRG_OFF_INIT_ROUND 8'h18
`define SLRG_OFF_FINAL_ROUND 8'h1C
`define SLRG_OFF_QS_DOWN 8'h20
`define SLRG_OFF_QS_INIT_ROUND 8'h24
`define SLRG_OFF_QS_FINAL_ROUND 8'h28
`define SLRG_OFF_SCALE 8'h2C
`define SLRG_OFF_STATUS 8'h30
`define SLRG_OFF_RAMP_OUT 8'h34

// control field positions
`define SLRG_CTRL_RAMP_EXT 0
`define SLRG_CTRL_ROUND_DISC 1
`define SLRG_CTRL_POS_SRC 2
`define SLRG_CTRL_NEG_SRC 3
`define SLRG_CTRL_UP_SRC 4
`define SLRG_CTRL_DOWN_SRC 5
`define SLRG_CTRL_BRAKE_FAULT 6
`define SLRG_CTRL_WIDTH 7

// status field positions
`define SLRG_STAT_OVERSPEED 0
`define SLRG_STAT_BRAKE_FAULT 1
`define SLRG_STAT_QS_ACTIVE 2
`define SLRG_STAT_AT_TARGET 3

// reset values (speeds in rpm, times in ms, scales in Q8.8)
`define SLRG_CTRL_RST 7'h01
`define SLRG_MAX_SPEED_RST 32'h000005DC
`define SLRG_POS_LIMIT_RST 32'h00033450
`define SLRG_NEG_LIMIT_RST 32'hFFFCCBB0
`define SLRG_RAMP_UP_RST 32'h00002710
`define SLRG_RAMP_DOWN_RST 32'h00002710
`define SLRG_ROUND_RST 32'h00000000
`define SLRG_QS_DOWN_RST 32'h00000000
`define SLRG_SCALE_RST 32'h01000100

// timing: clock rate and time unit of the time registers (ms)
`define SLRG_CLK_HZ 100000000
`define SLRG_TIME_UNIT_HZ 1000
`define SLRG_SCALE_FRAC 8
`define SLRG_RATE_FULL 9'h100

`endif

/* rtl/slrg_pkg.sv */
// types of the speed limit and ramp generator block
`default_nettype none
package slrg_pkg;

  // control register layout, msb first
  typedef struct packed {
    logic brakeFaultEn;
    logic downScaleExt;
    logic upScaleExt;
    logic negSrcExt;
    logic posSrcExt;
    logic roundDiscont;
    logic rampExt;
  } slrg_ctrl_s;

  // externally routed limit and scale sources
  typedef struct packed {
    logic signed [31:0] posLimit;
    logic signed [31:0] negLimit;
    logic [15:0] upScale;
    logic [15:0] downScale;
  } slrg_ext_s;

  // rounding phase of the ramp, gray along idle-rise-cruise-fall
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_RISE = 2'b01,
    PH_CRUISE = 2'b11,
    PH_FALL = 2'b10
  } slrg_phase_e;

endpackage
`default_nettype wire

/* rtl/slrg_top.sv */
// speed limit and ramp generator with wishbone register access
`include "slrg_defs.svh"
`default_nettype none
module slrg_top
  import slrg_pkg::*;
#(
  parameter int unsigned CLK_PER_UNIT = `SLRG_CLK_HZ / `SLRG_TIME_UNIT_HZ
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // setpoint side
  input wire logic signed [31:0] speedSetpoint,
  input wire logic signed [31:0] actualSpeed,
  input wire slrg_ext_s extSrc,
  input wire logic quickStopCmd,
  input wire logic currentLimitHit,
  input wire logic brakeLimitHit,
  // results
  output logic signed [31:0] rampOut,
  output logic signed [31:0] speedTarget,
  output logic overspeedAlarm,
  output logic brakeFault,
  output logic quickStopActive
);

  // settings
  slrg_ctrl_s ctrl;
  logic [31:0] maxSpeed;
  logic signed [31:0] posLimReg;
  logic signed [31:0] negLimReg;
  logic [31:0] rampUpTime;
  logic [31:0] rampDownTime;
  logic [31:0] initRound;
  logic [31:0] finalRound;
  logic [31:0] qsDownTime;
  logic [31:0] qsInitRound;
  logic [31:0] qsFinalRound;
  logic [31:0] scaleReg;
  logic overSticky;
  logic qsMeta;
  logic qsSync;

  // ramp state
  slrg_phase_e phase;
  logic [8:0] rateLvl;
  logic [55:0] stepAcc;
  logic [55:0] rateCnt;
  logic [32:0] riseSteps;
  logic lastUp;
  logic signed [31:0] lastTarget;

  // bus strobes
  logic busReq;
  logic wrStrobe;
  logic statClr;

  // merge write data with byte enables
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // one access per cycle; ack answers one cycle after the request
  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wrStrobe = busReq & wb_we_i;
  assign statClr = wrStrobe & (wb_adr_i == `SLRG_OFF_STATUS);

  // acknowledge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq;
    end
  end

  // settings writes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= slrg_ctrl_s'(`SLRG_CTRL_RST);
      maxSpeed <= `SLRG_MAX_SPEED_RST;
      posLimReg <= `SLRG_POS_LIMIT_RST;
      negLimReg <= `SLRG_NEG_LIMIT_RST;
      rampUpTime <= `SLRG_RAMP_UP_RST;
      rampDownTime <= `SLRG_RAMP_DOWN_RST;
      initRound <= `SLRG_ROUND_RST;
      finalRound <= `SLRG_ROUND_RST;
      qsDownTime <= `SLRG_QS_DOWN_RST;
      qsInitRound <= `SLRG_ROUND_RST;
      qsFinalRound <= `SLRG_ROUND_RST;
      scaleReg <= `SLRG_SCALE_RST;
    end else if (wrStrobe) begin
      if (wb_adr_i == `SLRG_OFF_CTRL) begin
        ctrl <= wb_sel_i[0] ? slrg_ctrl_s'(wb_dat_i[`SLRG_CTRL_WIDTH-1:0]) : ctrl;
      end else if (wb_adr_i == `SLRG_OFF_MAX_SPEED) begin
        maxSpeed <= wmerge(maxSpeed, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `SLRG_OFF_POS_LIMIT) begin
        posLimReg <= wmerge(posLimReg, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `SLRG_OFF_NEG_LIMIT) begin
        negLimReg <= wmerge(negLimReg, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `SLRG_OFF_RAMP_UP) begin
        rampUpTime <= wmerge(rampUpTime, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `SLRG_OFF_RAMP_DOWN) begin
        rampDownTime <= wmerge(rampDownTime, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `SLRG_OFF_INIT_ROUND) begin
        initRound <= wmerge(initRound, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `SLRG_OFF_FINAL_ROUND) begin
        finalRound <= wmerge(finalRound, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `SLRG_OFF_QS_DOWN) begin
        qsDownTime <= wmerge(qsDownTime, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `SLRG_OFF_QS_INIT_ROUND) begin
        qsInitRound <= wmerge(qsInitRound, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `SLRG_OFF_QS_FINAL_ROUND) begin
        qsFinalRound <= wmerge(qsFinalRound, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `SLRG_OFF_SCALE) begin
        scaleReg <= wmerge(scaleReg, wb_dat_i, wb_sel_i);
      end
    end
  end

  // quick stop pin synchroniser
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      qsMeta <= 1'b0;
      qsSync <= 1'b0;
      quickStopActive <= 1'b0;
    end else begin
      qsMeta <= quickStopCmd;
      qsSync <= qsMeta;
      quickStopActive <= qsSync;
    end
  end

  // limit selection and clamping
  logic signed [31:0] posLim;
  logic signed [31:0] negLim;
  logic signed [32:0] maxPos;
  logic signed [32:0] maxNeg;
  logic signed [32:0] clampMax;
  logic signed [32:0] clampDir;
  logic overNow;
  assign posLim = ctrl.posSrcExt ? extSrc.posLimit : posLimReg;
  assign negLim = ctrl.negSrcExt ? extSrc.negLimit : negLimReg;
  assign maxPos = $signed({1'b0, maxSpeed});
  assign maxNeg = -maxPos;
  always_comb begin
    clampMax = 33'(speedSetpoint);
    if (clampMax > maxPos) begin
      clampMax = maxPos;
    end else if (clampMax < maxNeg) begin
      clampMax = maxNeg;
    end
    clampDir = clampMax;
    if (clampDir > 33'(posLim)) begin
      clampDir = 33'(posLim);
    end else if (clampDir < 33'(negLim)) begin
      clampDir = 33'(negLim);
    end
  end
  assign overNow = (33'(actualSpeed) > maxPos) || (33'(actualSpeed) < maxNeg);

  // target register and overspeed alarm
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      speedTarget <= 32'h00000000;
      overspeedAlarm <= 1'b0;
      overSticky <= 1'b0;
    end else begin
      speedTarget <= quickStopActive ? 32'h00000000 : clampDir[31:0];
      overspeedAlarm <= overNow;
      overSticky <= overNow | (overSticky & ~(statClr & wb_dat_i[`SLRG_STAT_OVERSPEED]));
    end
  end

  // ramp time selection with run-time scaling
  logic [15:0] upScale;
  logic [15:0] downScale;
  logic [47:0] upProd;
  logic [47:0] downProd;
  logic [39:0] rampMs;
  logic [31:0] roundInMs;
  logic [31:0] roundOutMs;
  logic moving;
  logic dirUp;
  logic accel;
  assign upScale = ctrl.upScaleExt ? extSrc.upScale : scaleReg[15:0];
  assign downScale = ctrl.downScaleExt ? extSrc.downScale : scaleReg[31:16];
  assign upProd = rampUpTime * upScale;
  assign downProd = rampDownTime * downScale;
  assign moving = (rampOut != speedTarget);
  assign dirUp = (speedTarget > rampOut);
  assign accel = dirUp ? (rampOut >= 0) : (rampOut <= 0);
  always_comb begin
    if (accel) begin
      rampMs = upProd[47:`SLRG_SCALE_FRAC];
    end else if (quickStopActive) begin
      rampMs = {8'h00, qsDownTime};
    end else begin
      rampMs = downProd[47:`SLRG_SCALE_FRAC];
    end
  end
  assign roundInMs = quickStopActive ? qsInitRound : initRound;
  assign roundOutMs = quickStopActive ? qsFinalRound : finalRound;

  // per-step and per-level thresholds in clock cycles
  logic [71:0] thrProd;
  logic [55:0] stepThr;
  logic [63:0] inProd;
  logic [63:0] outProd;
  logic [55:0] inLvlClk;
  logic [55:0] outLvlClk;
  logic [8:0] rateEff;
  logic [40:0] incProd;
  logic [55:0] stepInc;
  logic [55:0] accSum;
  assign thrProd = rampMs * CLK_PER_UNIT;
  assign stepThr = thrProd[55:0];
  assign inProd = roundInMs * CLK_PER_UNIT;
  assign outProd = roundOutMs * CLK_PER_UNIT;
  assign inLvlClk = inProd[63:8];
  assign outLvlClk = outProd[63:8];
  assign rateEff = ctrl.rampExt ? rateLvl : `SLRG_RATE_FULL;
  assign incProd = maxSpeed * rateEff;
  assign stepInc = {23'h0, incProd[40:8]};
  assign accSum = stepAcc + stepInc;

  // remaining distance and hold conditions
  logic signed [32:0] diffSig;
  logic [32:0] remain;
  logic holdAccel;
  logic holdBrake;
  logic faultNow;
  logic freeze;
  logic restart;
  logic roundOut;
  assign diffSig = 33'(speedTarget) - 33'(rampOut);
  assign remain = diffSig[32] ? 33'(-diffSig) : 33'(diffSig);
  assign holdAccel = accel & currentLimitHit;
  assign holdBrake = ~accel & brakeLimitHit & ~ctrl.brakeFaultEn;
  assign faultNow = ~accel & brakeLimitHit & ctrl.brakeFaultEn & moving;
  assign freeze = holdAccel | holdBrake | brakeFault;
  assign restart = ~moving | (dirUp != lastUp) |
                   (ctrl.roundDiscont & (speedTarget != lastTarget));
  assign roundOut = (outLvlClk != 56'h0) & (remain <= riseSteps);

  // brake fault latch, cleared by writing one
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      brakeFault <= 1'b0;
    end else begin
      brakeFault <= faultNow |
                    (brakeFault & ~(statClr & wb_dat_i[`SLRG_STAT_BRAKE_FAULT]));
    end
  end

  // rounding phase and rate level
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= PH_IDLE;
      rateLvl <= 9'h000;
      rateCnt <= 56'h0;
      lastUp <= 1'b0;
      lastTarget <= 32'h00000000;
    end else begin
      lastUp <= dirUp;
      lastTarget <= speedTarget;
      rateCnt <= rateCnt + 56'h1;
      if (restart) begin
        phase <= PH_IDLE;
        rateLvl <= 9'h000;
        rateCnt <= 56'h0;
      end else begin
        case (phase)
          PH_IDLE: begin
            rateCnt <= 56'h0;
            if (inLvlClk == 56'h0) begin
              phase <= PH_CRUISE;
              rateLvl <= `SLRG_RATE_FULL;
            end else begin
              phase <= PH_RISE;
              rateLvl <= 9'h001;
            end
          end
          PH_RISE: begin
            if (roundOut) begin
              phase <= PH_FALL;
              rateCnt <= 56'h0;
            end else if (rateCnt >= inLvlClk) begin
              rateCnt <= 56'h0;
              rateLvl <= rateLvl + 9'h001;
              if (rateLvl == `SLRG_RATE_FULL - 9'h001) begin
                phase <= PH_CRUISE;
              end
            end
          end
          PH_CRUISE: begin
            if (roundOut) begin
              phase <= PH_FALL;
              rateCnt <= 56'h0;
            end
          end
          PH_FALL: begin
            if (rateCnt >= outLvlClk) begin
              rateCnt <= 56'h0;
              if (rateLvl > 9'h001) begin
                rateLvl <= rateLvl - 9'h001;
              end
            end
          end
          default: begin
            phase <= PH_IDLE;
          end
        endcase
      end
    end
  end

  // ramp output stepping
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rampOut <= 32'h00000000;
      stepAcc <= 56'h0;
      riseSteps <= 33'h0;
    end else if (restart) begin
      stepAcc <= 56'h0;
      riseSteps <= 33'h0;
    end else if (!freeze) begin
      if (stepThr == 56'h0) begin // only a zero ramp time jumps; short ones step at most once a clock
        rampOut <= speedTarget;
        stepAcc <= 56'h0;
      end else if (accSum >= stepThr) begin
        stepAcc <= accSum - stepThr;
        rampOut <= dirUp ? rampOut + 32'sd1 : rampOut - 32'sd1;
        if (phase == PH_RISE) begin
          riseSteps <= riseSteps + 33'h1;
        end
      end else begin
        stepAcc <= accSum;
      end
    end
  end

  // register read back
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h00000000;
    end else if (busReq && !wb_we_i) begin
      if (wb_adr_i == `SLRG_OFF_CTRL) begin
        wb_dat_o <= {25'h0, ctrl};
      end else if (wb_adr_i == `SLRG_OFF_MAX_SPEED) begin
        wb_dat_o <= maxSpeed;
      end else if (wb_adr_i == `SLRG_OFF_POS_LIMIT) begin
        wb_dat_o <= posLimReg;
      end else if (wb_adr_i == `SLRG_OFF_NEG_LIMIT) begin
        wb_dat_o <= negLimReg;
      end else if (wb_adr_i == `SLRG_OFF_RAMP_UP) begin
        wb_dat_o <= rampUpTime;
      end else if (wb_adr_i == `SLRG_OFF_RAMP_DOWN) begin
        wb_dat_o <= rampDownTime;
      end else if (wb_adr_i == `SLRG_OFF_INIT_ROUND) begin
        wb_dat_o <= initRound;
      end else if (wb_adr_i == `SLRG_OFF_FINAL_ROUND) begin
        wb_dat_o <= finalRound;
      end else if (wb_adr_i == `SLRG_OFF_QS_DOWN) begin
        wb_dat_o <= qsDownTime;
      end else if (wb_adr_i == `SLRG_OFF_QS_INIT_ROUND) begin
        wb_dat_o <= qsInitRound;
      end else if (wb_adr_i == `SLRG_OFF_QS_FINAL_ROUND) begin
        wb_dat_o <= qsFinalRound;
      end else if (wb_adr_i == `SLRG_OFF_SCALE) begin
        wb_dat_o <= scaleReg;
      end else if (wb_adr_i == `SLRG_OFF_STATUS) begin
        wb_dat_o <= {28'h0, ~moving, quickStopActive, brakeFault, overSticky};
      end else if (wb_adr_i == `SLRG_OFF_RAMP_OUT) begin
        wb_dat_o <= rampOut;
      end else begin
        wb_dat_o <= 32'h00000000; // unmapped reads as zero
      end
    end
  end

endmodule
`default_nettype wire

/* tb/slrg_top_sva.sv */
// port checker of the speed limit and ramp generator
`default_nettype none
module slrg_top_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // setpoint side
  input wire logic signed [31:0] actualSpeed,
  input wire logic quickStopCmd,
  // results
  input wire logic signed [31:0] rampOut,
  input wire logic signed [31:0] speedTarget,
  input wire logic overspeedAlarm,
  input wire logic brakeFault,
  input wire logic quickStopActive
);
  timeunit 1ns;
  timeprecision 100ps;
  // the bench keeps the maximum speed at its reset value
  localparam int MAXS = 1500;
  logic overNow;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // actual speed beyond the maximum in either direction
  assign overNow = (actualSpeed > MAXS) || (actualSpeed < -MAXS);
  // bus answers once, one cycle after the request
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered next cycle");
  // setpoint clamp and ramp stepping
  chk_target_bound: assert property (speedTarget <= MAXS && speedTarget >= -MAXS)
    else $error("target outside maximum speed");
  chk_ramp_toward: assert property (!$stable(rampOut) |->
    ((rampOut > $past(rampOut)) == ($past(speedTarget) > $past(rampOut))))
    else $error("ramp moved away from target");
  chk_ramp_step: assert property (!$stable(rampOut) |->
    (rampOut - $past(rampOut) == 1 || $past(rampOut) - rampOut == 1
     || rampOut == $past(speedTarget)))
    else $error("ramp step neither one nor a jump to target");
  // alarm follows the actual speed one cycle later
  chk_over_flag: assert property (1'b1 |=> (overspeedAlarm == $past(overNow)))
    else $error("overspeed alarm wrong");
  // quick stop pin through three register stages
  chk_qs_sync: assert property (quickStopCmd [*3] |=> quickStopActive)
    else $error("quick stop not taken");
  chk_qs_release: assert property (!quickStopCmd [*3] |=> !quickStopActive)
    else $error("quick stop not released");
  chk_qs_target: assert property (quickStopActive && $past(quickStopActive) |->
    speedTarget == 0)
    else $error("target not zero in quick stop");
  // a latched brake fault freezes the ramp
  chk_fault_freeze: assert property (brakeFault && $past(brakeFault) |-> $stable(rampOut))
    else $error("ramp moved during brake fault");
  // main scenarios seen
  cover property (quickStopActive && speedTarget == 0);
  cover property (brakeFault);
  cover property (overspeedAlarm);
endmodule
`default_nettype wire

/* tb/slrg_ctrl_model.sv */
// higher-level controller model publishing limit and scale words
`default_nettype none
module slrg_ctrl_model
  import slrg_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // words the controller wants to send
  input wire logic signed [31:0] posReq,
  input wire logic signed [31:0] negReq,
  input wire logic [15:0] upReq,
  input wire logic [15:0] downReq,
  // words seen by the block
  output var slrg_ext_s extSrc
);
  timeunit 1ns;
  timeprecision 100ps;
  // words refresh once a clock like a fieldbus receive word, scale 1.0 from reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      extSrc <= {32'sh00033450, 32'shFFFCCBB0, 16'h0100, 16'h0100};
    end else begin
      extSrc <= {posReq, negReq, upReq, downReq};
    end
  end
endmodule
`default_nettype wire

/* tb/slrg_top_tb_top.sv */
// self-checking bench of the speed limit and ramp generator
`include "slrg_defs.svh"
`default_nettype none
module slrg_top_tb_top
  import slrg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CPU = 10;
  logic mclk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, wbWe = 1'b0;
  logic qsCmd = 1'b0, curLim = 1'b0, brkLim = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, wbDat;
  logic signed [31:0] sp = 32'sh0, act = 32'sh0, posReq = 32'sh0, negReq = 32'sh0;
  logic [15:0] upReq = 16'h0100, downReq = 16'h0100;
  logic wbAck, overAl, brkFault, qsAct;
  logic signed [31:0] rampOut, speedTarget;
  slrg_ext_s extSrc;
  int badCount = 0;
  int nChecks = 0;
  logic [31:0] rstTab [12] = '{32'h01, 32'h5DC, 32'h33450, 32'hFFFCCBB0, 32'h2710, 32'h2710,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h01000100};
  int ctlTab [3] = '{0, 1, 3};
  int rndExp [3] = '{3000, 5560, 5560};
  int qsRnd [2] = '{0, 256};
  int qsExp [2] = '{4005, 6565};
  slrg_ctrl_model u_slrg_ctrl_model (.mclk(mclk), .rst_b(rst_b), .posReq(posReq),
    .negReq(negReq), .upReq(upReq), .downReq(downReq), .extSrc(extSrc));
  slrg_top #(.CLK_PER_UNIT(CPU)) u_slrg_top (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(wbWe), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wbDat), .wb_ack_o(wbAck), .speedSetpoint(sp), .actualSpeed(act),
    .extSrc(extSrc), .quickStopCmd(qsCmd), .currentLimitHit(curLim),
    .brakeLimitHit(brkLim), .rampOut(rampOut), .speedTarget(speedTarget),
    .overspeedAlarm(overAl), .brakeFault(brkFault), .quickStopActive(qsAct));
  // 100 MHz clock
  initial begin
    forever #5 mclk = ~mclk;
  end
  // verdict and end of run
  task automatic endSim();
    if (badCount == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // value comparison
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // duration comparison within a tolerance
  task automatic chkNear(input int got, input int exp, input int tol);
    nChecks++;
    if (got < exp - tol || got > exp + tol) begin
      badCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // one classic wishbone cycle, held until ack is sampled high
  task automatic wbX(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wbWe <= we;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (wbAck !== 1'b1) begin
      badCount++;
      endSim();
    end
    rdat = wbDat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wbX(1'b1, a, d, 4'hF);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wbX(1'b0, a, 32'h0, 4'hF);
    chkVal(rdat & m, e);
  endtask
  task automatic tgtChk(input logic signed [31:0] s, input logic signed [31:0] e);
    sp <= s;
    ticks(2);
    chkVal(speedTarget, e);
  endtask
  // drive a setpoint and time the ramp output until it reaches t
  task automatic rampTo(input logic signed [31:0] s, input logic signed [31:0] t,
    input int exp, input int tol);
    int n;
    n = 0;
    sp <= s;
    while (rampOut !== t && n < 4 * exp + 400) begin
      @(posedge mclk);
      n++;
    end
    if (rampOut !== t) begin
      badCount++;
      endSim();
    end
    chkNear(n, exp, tol);
  endtask
  // bring the ramp to standstill at once
  task automatic settle();
    wr(`SLRG_OFF_INIT_ROUND, 32'h0);
    wr(`SLRG_OFF_FINAL_ROUND, 32'h0);
    wr(`SLRG_OFF_RAMP_DOWN, 32'h0);
    rampTo(32'sh0, 32'sh0, 2, 1000);
  endtask
  // main sequence
  initial begin
    ticks(5);
    rst_b <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      rdChk(8'(4 * i), 32'hFFFFFFFF, rstTab[i]);
    end
    rdChk(8'h3C, 32'hFFFFFFFF, 32'h0);
    wr(8'h3C, 32'hFFFFFFFF);
    rdChk(8'h3C, 32'hFFFFFFFF, 32'h0);
    wbX(1'b1, `SLRG_OFF_RAMP_UP, 32'hFFFFFF2C, 4'h1);
    rdChk(`SLRG_OFF_RAMP_UP, 32'hFFFFFFFF, 32'h0000272C);
    tgtChk(32'sd2000, 32'sd1500);
    tgtChk(-32'sd3000, -32'sd1500);
    wr(`SLRG_OFF_POS_LIMIT, 32'd1000);
    wr(`SLRG_OFF_NEG_LIMIT, -32'sd700);
    tgtChk(32'sd2000, 32'sd1000);
    tgtChk(-32'sd3000, -32'sd700);
    posReq <= 32'sd800;
    negReq <= -32'sd600;
    wr(`SLRG_OFF_CTRL, 32'h0D);
    tgtChk(32'sd2000, 32'sd800);
    tgtChk(-32'sd3000, -32'sd600);
    wr(`SLRG_OFF_POS_LIMIT, `SLRG_POS_LIMIT_RST);
    wr(`SLRG_OFF_NEG_LIMIT, `SLRG_NEG_LIMIT_RST);
    act <= 32'sd1600;
    ticks(2);
    chkVal(overAl, 1'b1);
    act <= -32'sd1501;
    ticks(2);
    chkVal(overAl, 1'b1);
    act <= 32'sd1500;
    ticks(2);
    chkVal(overAl, 1'b0);
    rdChk(`SLRG_OFF_STATUS, 32'h1, 32'h1);
    wr(`SLRG_OFF_STATUS, 32'h1);
    rdChk(`SLRG_OFF_STATUS, 32'h1, 32'h0);
    // basic ramp timing, then run-time scaling
    settle();
    wr(`SLRG_OFF_CTRL, 32'h0);
    wr(`SLRG_OFF_RAMP_UP, 32'd300);
    wr(`SLRG_OFF_RAMP_DOWN, 32'd150);
    rampTo(32'sd1500, 32'sd1500, 300 * CPU, 6);
    rdChk(`SLRG_OFF_RAMP_OUT, 32'hFFFFFFFF, 32'd1500);
    rdChk(`SLRG_OFF_STATUS, 32'h8, 32'h8);
    rampTo(32'sd0, 32'sd0, 150 * CPU, 6);
    upReq <= 16'h0080;
    wr(`SLRG_OFF_CTRL, 32'h10);
    rampTo(32'sd1500, 32'sd1500, 150 * CPU, 6);
    wr(`SLRG_OFF_SCALE, 32'h02000100);
    rampTo(32'sd0, 32'sd0, 300 * CPU, 6);
    // current limit holds the ramp back
    curLim <= 1'b1;
    sp <= 32'sd1500;
    ticks(200);
    chkVal(rampOut, 32'h0);
    curLim <= 1'b0;
    rampTo(32'sd1500, 32'sd1500, 150 * CPU, 6);
    // braking overload: stretch, then fault
    brkLim <= 1'b1;
    sp <= 32'sd0;
    ticks(200);
    chkVal(rampOut, 32'd1500);
    wr(`SLRG_OFF_CTRL, 32'h50);
    ticks(4);
    chkVal(brkFault, 1'b1);
    brkLim <= 1'b0;
    ticks(50);
    chkVal(rampOut, 32'd1500);
    rdChk(`SLRG_OFF_STATUS, 32'h2, 32'h2);
    wr(`SLRG_OFF_STATUS, 32'h2);
    ticks(2);
    chkVal(brkFault, 1'b0);
    // rounding: basic ignores it, both smoothing types lengthen the ramp
    for (int i = 0; i < 3; i++) begin
      settle();
      wr(`SLRG_OFF_CTRL, ctlTab[i]);
      wr(`SLRG_OFF_RAMP_UP, 32'd300);
      wr(`SLRG_OFF_INIT_ROUND, 32'd256);
      wr(`SLRG_OFF_FINAL_ROUND, 32'd256);
      rampTo(32'sd1500, 32'sd1500, rndExp[i], rndExp[i] / 40);
    end
    // quick stop with its own time and roundings, not scaled
    for (int i = 0; i < 2; i++) begin
      settle();
      wr(`SLRG_OFF_CTRL, i);
      wr(`SLRG_OFF_RAMP_UP, 32'd0);
      rampTo(32'sd1500, 32'sd1500, 2, 1000);
      wr(`SLRG_OFF_QS_DOWN, 32'd400);
      wr(`SLRG_OFF_QS_INIT_ROUND, qsRnd[i]);
      wr(`SLRG_OFF_QS_FINAL_ROUND, qsRnd[i]);
      qsCmd <= 1'b1;
      rampTo(32'sd1500, 32'sd0, qsExp[i], qsExp[i] / 40);
      chkVal(speedTarget, 32'h0);
      rdChk(`SLRG_OFF_STATUS, 32'h4, 32'h4);
      qsCmd <= 1'b0;
      ticks(4);
    end
    endSim();
  end
endmodule
bind slrg_top slrg_top_sva u_slrg_top_sva (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .actualSpeed(actualSpeed),
  .quickStopCmd(quickStopCmd), .rampOut(rampOut), .speedTarget(speedTarget),
  .overspeedAlarm(overspeedAlarm), .brakeFault(brakeFault), .quickStopActive(quickStopActive));
`default_nettype wire
